// [design/qfb_pkg.sv]
// Purpose: Shared constants and carrier types for the queue flag bus block
// Assumes: One clock carries both read-port and write-port logic
// Notes: Quadrants are counted 0..3 inside, shown to users as 1..4
package qfb_pkg;

  // Widths and counts
  localparam int QFB_DATA_W = 40;
  localparam int QFB_ADDR_W = 8;
  localparam int QFB_ID_W = 3;
  localparam int QFB_QUAD_W = 8;
  localparam int QFB_NUM_QUADS = 4;
  localparam int QFB_NUM_QUEUES = QFB_NUM_QUADS * QFB_QUAD_W;

  // Queue address fields
  localparam int QFB_ADDR_ID_LSB = 5;
  localparam int QFB_ADDR_QUAD_LSB = 3;
  localparam int QFB_ADDR_QUEUE_LSB = 0;

  // Reset values and quadrant sequence
  localparam logic QFB_FLAG_IDLE_N = 1'b1;
  localparam logic [1:0] QFB_QUAD_FIRST = 2'h0;
  localparam logic [1:0] QFB_QUAD_LAST = 2'h3;
  localparam logic [QFB_QUAD_W-1:0] QFB_BUS_IDLE_N = 8'hFF;
  localparam logic QFB_MODE_DIRECT = 1'b0;
  localparam logic QFB_MODE_POLLED = 1'b1;
  localparam logic QFB_REPORT_ALMOST_EMPTY = 1'b0;

  // Pin group of one quadrant status bus
  typedef struct packed {
    logic [QFB_QUAD_W-1:0] flags_n;
    logic oe;
    logic sync;
    logic token_out;
  } qfb_quad_bus_t;

  // Decoded queue address
  typedef struct packed {
    logic [QFB_ID_W-1:0] dev_id;
    logic [1:0] quad;
    logic [2:0] line;
  } qfb_qaddr_t;

endpackage

// [design/qfb_quad_bus.sv]
// Purpose: One 8-bit quadrant status bus, direct or polled with token chain
// Assumes: Strobe, address and token are synchronous to clk_i
// Notes: Flags are active low on the bus; flags stay driven and oe is low when not owned
`timescale 1ns/1ps
module qfb_quad_bus
  import qfb_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic polled_i,
  input wire logic primary_i,
  input wire logic [QFB_ID_W-1:0] dev_id_i,
  input wire logic strobe_i,
  input wire qfb_qaddr_t addr_i,
  input wire logic [QFB_NUM_QUEUES-1:0] status_i,
  input wire logic mirror_en_i,
  input wire logic [1:0] mirror_quad_i,
  input wire logic [2:0] mirror_line_i,
  input wire logic mirror_flag_n_i,
  input wire logic token_in_i,
  output qfb_quad_bus_t bus_o
);

  logic [1:0] quad_ff;
  logic own_ff;
  logic [QFB_QUAD_W-1:0] flags_n_ff;
  logic [1:0] nxt_quad;
  logic nxt_own;
  logic [QFB_QUAD_W-1:0] nxt_flags_n;
  logic id_hit;
  logic at_last;

  // ----------------------------------------
  // Quadrant selection
  // ----------------------------------------
  assign id_hit = (addr_i.dev_id == dev_id_i);
  assign at_last = own_ff && (quad_ff == QFB_QUAD_LAST);

  // Direct picks by strobe; polled walks and passes the token
  always_comb begin
    nxt_quad = quad_ff;
    nxt_own = own_ff;
    if (polled_i) begin
      if (token_in_i) begin
        nxt_own = 1'b1;
        nxt_quad = QFB_QUAD_FIRST;
      end else if (at_last) begin
        nxt_own = 1'b0; // Hand bus to next device
      end else if (own_ff) begin
        nxt_quad = quad_ff + 2'h1;
      end
    end else if (strobe_i) begin
      nxt_own = id_hit;
      nxt_quad = addr_i.quad;
    end
  end

  // Status of the quadrant to be shown, with optional mirror line
  always_comb begin
    nxt_flags_n = ~status_i[nxt_quad*QFB_QUAD_W +: QFB_QUAD_W];
    if (mirror_en_i && (mirror_quad_i == nxt_quad)) begin
      nxt_flags_n[mirror_line_i] = mirror_flag_n_i;
    end
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      quad_ff <= QFB_QUAD_FIRST;
      own_ff <= 1'b0;
      flags_n_ff <= QFB_BUS_IDLE_N;
    end else begin
      quad_ff <= nxt_quad;
      own_ff <= nxt_own;
      flags_n_ff <= nxt_flags_n;
    end
  end

  // Primary starts the poll after reset with no token
  logic start_ff;
  always_ff @(posedge clk_i) begin
    start_ff <= srst_i;
  end

  // ----------------------------------------
  // Pin outputs
  // ----------------------------------------
  assign bus_o.flags_n = flags_n_ff;
  assign bus_o.oe = own_ff;
  assign bus_o.sync = polled_i && own_ff &&
                      (quad_ff == QFB_QUAD_FIRST);
  assign bus_o.token_out = polled_i &&
                           (at_last || (start_ff && primary_i));

endmodule

// [design/qfb_top.sv]
// Purpose: Read bus drive control, queue flags and quadrant flag buses
// Assumes: Queue status vectors come from the queue core on clk_i
// Notes: srst_i is the master reset; strap inputs are caught during it
`timescale 1ns/1ps
module qfb_top
  import qfb_pkg::*;
#(
  parameter int DATA_W = QFB_DATA_W
)(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic flag_mode_select_i,
  input wire logic primary_device_select_i,
  input wire logic [QFB_ID_W-1:0] device_id_i,
  input wire logic serial_program_done_i,
  input wire logic output_enable_n_i,
  input wire logic pll_enable_i,
  input wire logic [DATA_W-1:0] read_data_i,
  input wire logic [QFB_ADDR_W-1:0] read_queue_address_i,
  input wire logic read_address_strobe_i,
  input wire logic empty_quadrant_strobe_i,
  input wire logic [QFB_ADDR_W-1:0] write_queue_address_i,
  input wire logic write_address_strobe_i,
  input wire logic full_quadrant_strobe_i,
  input wire logic [QFB_NUM_QUEUES-1:0] almost_empty_status_i,
  input wire logic [QFB_NUM_QUEUES-1:0] packet_ready_status_i,
  input wire logic [QFB_NUM_QUEUES-1:0] almost_full_status_i,
  input wire logic empty_report_load_i,
  input wire logic empty_report_packet_i,
  input wire logic empty_mirror_en_i,
  input wire logic full_mirror_en_i,
  input wire logic empty_bus_token_in_i,
  input wire logic full_bus_token_in_i,
  output logic [DATA_W-1:0] read_data_o,
  output logic read_data_oe_o,
  output logic almost_empty_flag_n_o,
  output logic almost_full_flag_n_o,
  output logic [QFB_QUAD_W-1:0] almost_empty_quadrant_bus_o,
  output logic almost_empty_quadrant_bus_oe_o,
  output logic empty_bus_sync_o,
  output logic empty_bus_token_out_o,
  output logic [QFB_QUAD_W-1:0] almost_full_quadrant_bus_o,
  output logic almost_full_quadrant_bus_oe_o,
  output logic full_bus_sync_o,
  output logic full_bus_token_out_o
);

  // ----------------------------------------
  // Straps caught at master reset
  // ----------------------------------------
  logic polled_ff;
  logic primary_ff;
  logic [QFB_ID_W-1:0] dev_id_ff;

  // Mode, role and identity held from reset to next reset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      polled_ff <= flag_mode_select_i;
      primary_ff <= primary_device_select_i;
      dev_id_ff <= device_id_i;
    end
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  qfb_qaddr_t rd_addr;
  qfb_qaddr_t wr_addr;
  logic rd_hit;
  logic wr_hit;
  logic rd_sel_take;
  logic wr_sel_take;
  logic empty_strobe_ok;
  logic full_strobe_ok;

  assign rd_addr = qfb_qaddr_t'(read_queue_address_i);
  assign wr_addr = qfb_qaddr_t'(write_queue_address_i);
  assign rd_hit = (rd_addr.dev_id == dev_id_ff);
  assign wr_hit = (wr_addr.dev_id == dev_id_ff);

  // Selections are ignored until programming has finished
  assign rd_sel_take = read_address_strobe_i && serial_program_done_i;
  assign wr_sel_take = write_address_strobe_i && serial_program_done_i;
  assign empty_strobe_ok = empty_quadrant_strobe_i && serial_program_done_i;
  assign full_strobe_ok = full_quadrant_strobe_i &&
                          serial_program_done_i;

  // ----------------------------------------
  // Read queue selection
  // ----------------------------------------
  logic rd_own_ff;
  logic rd_ever_ff;
  logic [1:0] rd_quad_ff;
  logic [2:0] rd_line_ff;
  logic nxt_rd_own;

  assign nxt_rd_own = rd_sel_take ? rd_hit : rd_own_ff;

  // Queue chosen for reading and whether it lives here
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rd_own_ff <= 1'b0;
      rd_ever_ff <= 1'b0;
      rd_quad_ff <= QFB_QUAD_FIRST;
      rd_line_ff <= 3'h0;
    end else begin
      rd_own_ff <= nxt_rd_own;
      rd_ever_ff <= rd_ever_ff || (rd_sel_take && rd_hit);
      if (rd_sel_take) begin
        rd_quad_ff <= rd_addr.quad;
        rd_line_ff <= rd_addr.line;
      end
    end
  end

  // ----------------------------------------
  // Write queue selection
  // ----------------------------------------
  logic wr_own_ff;
  logic [1:0] wr_quad_ff;
  logic [2:0] wr_line_ff;

  // Queue chosen for writing and whether it lives here
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_own_ff <= 1'b0;
      wr_quad_ff <= QFB_QUAD_FIRST;
      wr_line_ff <= 3'h0;
    end else if (wr_sel_take) begin
      wr_own_ff <= wr_hit;
      wr_quad_ff <= wr_addr.quad;
      wr_line_ff <= wr_addr.line;
    end
  end

  // ----------------------------------------
  // Single queue flags
  // ----------------------------------------
  logic [4:0] rd_index;
  logic [4:0] wr_index;
  logic rd_almost_empty;
  logic wr_almost_full;
  logic pae_n_ff;
  logic paf_n_ff;

  assign rd_index = {rd_quad_ff, rd_line_ff};
  assign wr_index = {wr_quad_ff, wr_line_ff};
  assign rd_almost_empty = rd_own_ff && almost_empty_status_i[rd_index];
  assign wr_almost_full = wr_own_ff && almost_full_status_i[wr_index];

  // Flags change only on the clock edge
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pae_n_ff <= QFB_FLAG_IDLE_N;
      paf_n_ff <= QFB_FLAG_IDLE_N;
    end else begin
      pae_n_ff <= ~rd_almost_empty;
      paf_n_ff <= ~wr_almost_full;
    end
  end

  assign almost_empty_flag_n_o = pae_n_ff;
  assign almost_full_flag_n_o = paf_n_ff;

  // ----------------------------------------
  // Empty bus reporting kind
  // ----------------------------------------
  logic report_packet_ff;
  logic [QFB_NUM_QUEUES-1:0] empty_bus_status;

  // Reset returns to almost-empty reporting
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      report_packet_ff <= QFB_REPORT_ALMOST_EMPTY;
    end else if (empty_report_load_i) begin
      report_packet_ff <= empty_report_packet_i;
    end
  end

  assign empty_bus_status = report_packet_ff ? packet_ready_status_i :
                            almost_empty_status_i;

  // ----------------------------------------
  // Quadrant status buses
  // ----------------------------------------
  qfb_quad_bus_t empty_bus;
  qfb_quad_bus_t full_bus;

  // Empty bus follows read-side selection
  qfb_quad_bus u_empty_bus (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .polled_i(polled_ff),
    .primary_i(primary_ff),
    .dev_id_i(dev_id_ff),
    .strobe_i(empty_strobe_ok),
    .addr_i(rd_addr),
    .status_i(empty_bus_status),
    .mirror_en_i(empty_mirror_en_i && rd_own_ff),
    .mirror_quad_i(rd_quad_ff),
    .mirror_line_i(rd_line_ff),
    .mirror_flag_n_i(~rd_almost_empty),
    .token_in_i(empty_bus_token_in_i),
    .bus_o(empty_bus)
  );

  // Full bus follows write-side selection
  qfb_quad_bus u_full_bus (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .polled_i(polled_ff),
    .primary_i(primary_ff),
    .dev_id_i(dev_id_ff),
    .strobe_i(full_strobe_ok),
    .addr_i(wr_addr),
    .status_i(almost_full_status_i),
    .mirror_en_i(full_mirror_en_i && wr_own_ff),
    .mirror_quad_i(wr_quad_ff),
    .mirror_line_i(wr_line_ff),
    .mirror_flag_n_i(~wr_almost_full),
    .token_in_i(full_bus_token_in_i),
    .bus_o(full_bus)
  );

  assign almost_empty_quadrant_bus_o = empty_bus.flags_n;
  assign almost_empty_quadrant_bus_oe_o = empty_bus.oe;
  assign empty_bus_sync_o = empty_bus.sync;
  assign empty_bus_token_out_o = empty_bus.token_out;
  assign almost_full_quadrant_bus_o = full_bus.flags_n;
  assign almost_full_quadrant_bus_oe_o = full_bus.oe;
  assign full_bus_sync_o = full_bus.sync;
  assign full_bus_token_out_o = full_bus.token_out;

  // ----------------------------------------
  // Read data output path
  // ----------------------------------------
  logic [DATA_W-1:0] rd_stage_ff;
  logic [DATA_W-1:0] rd_late_ff;
  logic drive_ok;

  // PLL path launches one stage earlier than the plain path
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rd_stage_ff <= '0;
      rd_late_ff <= '0;
    end else begin
      rd_stage_ff <= read_data_i;
      rd_late_ff <= rd_stage_ff;
    end
  end

  assign read_data_o = pll_enable_i ? rd_stage_ff : rd_late_ff;

  // Primary follows enable; secondary waits for first read selection of one of its own queues
  assign drive_ok = primary_ff || rd_ever_ff;
  assign read_data_oe_o = drive_ok && !output_enable_n_i;

endmodule

// [test/qfb_core_model.sv]
// Purpose: Queue core status source and flag bus token loop
// Assumes: Single device wired back to itself
// Notes: Fixed status patterns keep every flag predictable
`timescale 1ns/1ps
module qfb_core_model
  import qfb_pkg::*;
#(
  parameter logic [QFB_NUM_QUEUES-1:0] AE = 32'h0,
  parameter logic [QFB_NUM_QUEUES-1:0] PR = 32'h0,
  parameter logic [QFB_NUM_QUEUES-1:0] AF = 32'h0
)(
  input wire logic clk_i,
  input wire logic empty_token_i,
  input wire logic full_token_i,
  output logic [QFB_NUM_QUEUES-1:0] ae_o,
  output logic [QFB_NUM_QUEUES-1:0] pr_o,
  output logic [QFB_NUM_QUEUES-1:0] af_o,
  output logic empty_token_o,
  output logic full_token_o
);
  // Status launched on the core clock
  always_ff @(posedge clk_i) begin
    ae_o <= AE;
    pr_o <= PR;
    af_o <= AF;
  end
  // Token out fed straight back to token in
  assign empty_token_o = empty_token_i;
  assign full_token_o = full_token_i;
endmodule

// [test/qfb_sva.sv]
// Purpose: Port assertions for the queue flag bus block
// Assumes: Single device, token outputs looped back to token inputs
// Notes: Straps change only while srst_i is high
`timescale 1ns/1ps
module qfb_sva
  import qfb_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic primary_device_select_i,
  input wire logic [QFB_ID_W-1:0] device_id_i,
  input wire logic serial_program_done_i,
  input wire logic output_enable_n_i,
  input wire logic [QFB_ADDR_W-1:0] read_queue_address_i,
  input wire logic read_address_strobe_i,
  input wire logic [QFB_ADDR_W-1:0] write_queue_address_i,
  input wire logic write_address_strobe_i,
  input wire logic full_quadrant_strobe_i,
  input wire logic [QFB_NUM_QUEUES-1:0] almost_empty_status_i,
  input wire logic [QFB_NUM_QUEUES-1:0] almost_full_status_i,
  input wire logic full_bus_token_in_i,
  input wire logic read_data_oe_o,
  input wire logic almost_empty_flag_n_o,
  input wire logic almost_full_flag_n_o,
  input wire logic almost_full_quadrant_bus_oe_o,
  input wire logic empty_bus_sync_o,
  input wire logic full_bus_sync_o,
  input wire logic full_bus_token_out_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // ----
  // Selected queue tracking
  // ----
  logic [4:0] rq_ff;
  logic [4:0] wq_ff;
  wire rsel = read_address_strobe_i && serial_program_done_i &&
    read_queue_address_i[7:5] == device_id_i;
  wire wsel = write_address_strobe_i && serial_program_done_i &&
    write_queue_address_i[7:5] == device_id_i;
  always_ff @(posedge clk_i) begin
    if (rsel) rq_ff <= read_queue_address_i[4:0];
    if (wsel) wq_ff <= write_queue_address_i[4:0];
  end
  // ----
  // Properties
  // ----
  property p_oe_off;
    output_enable_n_i |-> !read_data_oe_o;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("read bus driven while disabled");
  property p_prim_drive;
    primary_device_select_i && !output_enable_n_i |-> read_data_oe_o;
  endproperty
  a_prim_drive: assert property (p_prim_drive)
    else $error("primary not driving read bus");
  property p_rd_flag;
    rsel ##1 !rsel |=>
      almost_empty_flag_n_o == !$past(almost_empty_status_i[rq_ff]);
  endproperty
  a_rd_flag: assert property (p_rd_flag)
    else $error("empty flag wrong for read queue");
  property p_wr_flag;
    wsel ##1 !wsel |=>
      almost_full_flag_n_o == !$past(almost_full_status_i[wq_ff]);
  endproperty
  a_wr_flag: assert property (p_wr_flag)
    else $error("full flag wrong for write queue");
  property p_fdir_own;
    full_quadrant_strobe_i && serial_program_done_i &&
      write_queue_address_i[7:5] == device_id_i |=>
      almost_full_quadrant_bus_oe_o;
  endproperty
  a_fdir_own: assert property (p_fdir_own)
    else $error("full bus not owned after select");
  property p_full_bus_sync_gap;
    full_bus_sync_o |=> !full_bus_sync_o [*3] ##1 full_bus_sync_o;
  endproperty
  a_full_bus_sync_gap: assert property (p_full_bus_sync_gap)
    else $error("full sync spacing wrong");
  property p_fquad_tok;
    full_bus_sync_o |-> ##3 full_bus_token_out_o;
  endproperty
  a_fquad_tok: assert property (p_fquad_tok)
    else $error("token not with fourth quadrant");
  property p_tok_wrap;
    full_bus_token_in_i |=> full_bus_sync_o;
  endproperty
  a_tok_wrap: assert property (p_tok_wrap)
    else $error("first quadrant not after token");
  property p_esync_gap;
    empty_bus_sync_o |=> !empty_bus_sync_o [*3] ##1 empty_bus_sync_o;
  endproperty
  a_esync_gap: assert property (p_esync_gap)
    else $error("empty sync spacing wrong");
  // Main scenarios reached
  c_rsel: cover property (rsel ##2 !almost_empty_flag_n_o);
  c_ftok: cover property (full_bus_token_out_o);
  c_fown: cover property (almost_full_quadrant_bus_oe_o);
endmodule

// [test/qfb_top_tb.sv]
// Purpose: Self-checking bench for the queue flag bus block
// Assumes: Inputs change by non-blocking assignment at rising edges
// Notes: Outputs are judged at falling edges
`timescale 1ns/1ps
module qfb_top_tb;
  import qfb_pkg::*;
  localparam logic [31:0] AE = 32'h96C32D4B;
  localparam logic [31:0] AF = 32'h5AA53C0F;
  localparam logic [31:0] PR = 32'h12488421;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic flag_mode_select_i = 1'b0;
  logic primary_device_select_i = 1'b1;
  logic [2:0] device_id_i = 3'h0;
  logic serial_program_done_i = 1'b1;
  logic output_enable_n_i = 1'b1;
  logic pll_enable_i = 1'b0;
  logic [39:0] read_data_i = 40'h0;
  logic [7:0] read_queue_address_i = 8'h0;
  logic [7:0] write_queue_address_i = 8'h0;
  logic read_address_strobe_i = 1'b0;
  logic write_address_strobe_i = 1'b0;
  logic empty_quadrant_strobe_i = 1'b0;
  logic full_quadrant_strobe_i = 1'b0;
  logic empty_report_load_i = 1'b0;
  logic empty_report_packet_i = 1'b0;
  logic empty_mirror_en_i = 1'b0;
  logic full_mirror_en_i = 1'b0;
  logic [31:0] almost_empty_status_i, packet_ready_status_i;
  logic [31:0] almost_full_status_i;
  logic empty_bus_token_in_i, full_bus_token_in_i;
  logic [39:0] read_data_o;
  logic [7:0] almost_empty_quadrant_bus_o, almost_full_quadrant_bus_o;
  logic read_data_oe_o, almost_empty_flag_n_o, almost_full_flag_n_o;
  logic almost_empty_quadrant_bus_oe_o, almost_full_quadrant_bus_oe_o;
  logic empty_bus_sync_o, empty_bus_token_out_o, full_bus_sync_o;
  logic full_bus_token_out_o;
  int checks = 0;
  int mismatches = 0;
  // ----
  // Design, core model and clock
  // ----
  qfb_top qfb_top_i (.*);
  qfb_core_model #(.AE(AE), .PR(PR), .AF(AF)) qfb_core_model_i (
    .clk_i(clk_i),
    .empty_token_i(empty_bus_token_out_o),
    .full_token_i(full_bus_token_out_o),
    .ae_o(almost_empty_status_i),
    .pr_o(packet_ready_status_i),
    .af_o(almost_full_status_i),
    .empty_token_o(empty_bus_token_in_i),
    .full_token_o(full_bus_token_in_i)
  );
  always #25 clk_i = ~clk_i;
  // ----
  // Shared tasks
  // ----
  task automatic chk(input string n, input logic [39:0] s, e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic do_reset(input logic fm, pr);
    @(posedge clk_i);
    srst_i <= 1'b1;
    flag_mode_select_i <= fm;
    primary_device_select_i <= pr;
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
  endtask
  // Queue select on both ports, d low means programming unfinished
  task automatic sel(input logic [7:0] a, input logic d);
    @(posedge clk_i);
    serial_program_done_i <= d;
    read_queue_address_i <= a;
    write_queue_address_i <= a;
    read_address_strobe_i <= 1'b1;
    write_address_strobe_i <= 1'b1;
    @(posedge clk_i);
    serial_program_done_i <= 1'b1;
    read_address_strobe_i <= 1'b0;
    write_address_strobe_i <= 1'b0;
    repeat (2) @(negedge clk_i);
  endtask
  // Direct quadrant select on both buses
  task automatic qsel(input logic [7:0] a);
    @(posedge clk_i);
    read_queue_address_i <= a;
    write_queue_address_i <= a;
    empty_quadrant_strobe_i <= 1'b1;
    full_quadrant_strobe_i <= 1'b1;
    @(posedge clk_i);
    empty_quadrant_strobe_i <= 1'b0;
    full_quadrant_strobe_i <= 1'b0;
    repeat (2) @(negedge clk_i);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_read_bus;
    @(posedge clk_i);
    output_enable_n_i <= 1'b0;
    pll_enable_i <= 1'b1;
    read_data_i <= 40'hA5A5A5A5A5;
    @(negedge clk_i);
    chk("rd_oe", read_data_oe_o, 1'b1);
    @(negedge clk_i);
    chk("rd_pll", read_data_o, 40'hA5A5A5A5A5);
    @(posedge clk_i);
    pll_enable_i <= 1'b0;
    read_data_i <= 40'h0F0F0F0F0F;
    repeat (2) @(negedge clk_i);
    chk("rd_lat1", read_data_o, 40'hA5A5A5A5A5);
    @(negedge clk_i);
    chk("rd_lat2", read_data_o, 40'h0F0F0F0F0F);
    @(posedge clk_i);
    output_enable_n_i <= 1'b1;
    @(negedge clk_i);
    chk("rd_off", read_data_oe_o, 1'b0);
    $display("t_read_bus done");
  endtask
  task automatic t_select;
    for (int q = 3; q < 32; q += 10) begin
      sel(8'(q), 1'b1);
      chk("ae_flag", almost_empty_flag_n_o, !AE[q]);
      chk("af_flag", almost_full_flag_n_o, !AF[q]);
    end
    // Select refused while programming unfinished
    sel(8'h0E, 1'b0);
    @(negedge clk_i);
    chk("ae_hold", almost_empty_flag_n_o, !AE[23]);
    $display("t_select done");
  endtask
  task automatic t_direct;
    for (int k = 0; k < 4; k++) begin
      qsel({3'h0, 2'(k), 3'h0});
      chk("ae_bus", almost_empty_quadrant_bus_o,
        8'(~AE[k*8+:8]));
      chk("af_bus", almost_full_quadrant_bus_o,
        8'(~AF[k*8+:8]));
      chk("af_oe", almost_full_quadrant_bus_oe_o, 1'b1);
    end
    qsel(8'h20);
    chk("ae_oe", almost_empty_quadrant_bus_oe_o, 1'b0);
    chk("af_oe", almost_full_quadrant_bus_oe_o, 1'b0);
    @(posedge clk_i);
    empty_report_load_i <= 1'b1;
    empty_report_packet_i <= 1'b1;
    @(posedge clk_i);
    empty_report_load_i <= 1'b0;
    qsel(8'h00);
    chk("pr_bus", almost_empty_quadrant_bus_o, 8'(~PR[7:0]));
    // Mirror lines of the selected queues, quadrant 2 line 7
    @(posedge clk_i);
    empty_mirror_en_i <= 1'b1;
    full_mirror_en_i <= 1'b1;
    qsel(8'h10);
    chk("ae_mir", almost_empty_quadrant_bus_o,
      8'({!AE[23], ~PR[22:16]}));
    chk("af_mir", almost_full_quadrant_bus_o, 8'(~AF[23:16]));
    @(posedge clk_i);
    empty_mirror_en_i <= 1'b0;
    full_mirror_en_i <= 1'b0;
    $display("t_direct done");
  endtask
  task automatic t_polled;
    do_reset(1'b1, 1'b1);
    flag_mode_select_i <= 1'b0;
    for (int b = 0; b < 2; b++) begin
      for (int i = 0; i < 12; i++) begin
        @(negedge clk_i);
        if ((b ? empty_bus_sync_o : full_bus_sync_o) === 1'b1) break;
      end
      for (int k = 0; k < 5; k++) begin
        chk("sync", b ? empty_bus_sync_o : full_bus_sync_o,
          k % 4 == 0);
        chk("tok", b ? empty_bus_token_out_o : full_bus_token_out_o,
          k == 3);
        chk("bus",
          b ? almost_empty_quadrant_bus_o : almost_full_quadrant_bus_o,
          8'(~((b ? AE : AF) >> (k % 4 * 8))));
        @(negedge clk_i);
      end
    end
    $display("t_polled done");
  endtask
  task automatic t_secondary;
    do_reset(1'b0, 1'b0);
    @(posedge clk_i);
    output_enable_n_i <= 1'b0;
    repeat (2) @(negedge clk_i);
    chk("sec_off", read_data_oe_o, 1'b0);
    sel(8'h02, 1'b1);
    chk("sec_on", read_data_oe_o, 1'b1);
    $display("t_secondary done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----
  // Main sequence and watchdog
  // ----
  initial begin
    do_reset(1'b0, 1'b1);
    t_read_bus();
    t_select();
    t_direct();
    t_polled();
    t_secondary();
    test_done();
  end
  initial begin
    #(50 * 3000);
    mismatches++;
    test_done();
  end
endmodule
bind qfb_top qfb_sva qfb_sva_i (.*);
